// ==== shared/sram_sel_pkg.sv ====
// shared constants and types of the secure byte-wide bus select block
package sram_sel_pkg;
  // ***********************************************
  // widths
  // ***********************************************
  localparam int ADDR_W     = 16;
  localparam int PHYS_W     = 15;
  localparam int KEY_W      = 64;
  localparam int VEC_AW     = 6;
  localparam int REG_AW     = 4;
  localparam int DATA_W     = 8;
  localparam int LOAD_CNT_W = 6;
  // ***********************************************
  // register offsets and fields
  // ***********************************************
  localparam logic [REG_AW-1:0] REG_CONFIG   = 4'h0;
  localparam logic [REG_AW-1:0] REG_CONTROL  = 4'h1;
  localparam logic [REG_AW-1:0] REG_STATUS   = 4'h2;
  localparam logic [REG_AW-1:0] REG_VEC_ADDR = 4'h3;
  localparam logic [REG_AW-1:0] REG_VEC_DATA = 4'h4;
  localparam int CFG_PES_BIT    = 0;
  localparam int CFG_LOCK_BIT   = 1;
  localparam int CTL_KEYGEN_BIT = 0;
  localparam int ST_LOADER = 0;
  localparam int ST_ERASE  = 1;
  localparam int ST_BACKUP = 2;
  localparam int ST_RESET  = 3;
  localparam int ST_KEYOK  = 4;
  localparam int ST_SUPPLY = 5;
  // ***********************************************
  // decode, loader and erase constants
  // ***********************************************
  localparam logic [ADDR_W-1:0] PE_BASE [0:3] = '{16'h0000, 16'h4000, 16'h8000, 16'hC000};
  localparam logic [ADDR_W-1:0] PE_TOP  [0:3] = '{16'h3FFF, 16'h7FFF, 16'hBFFF, 16'hFFFF};
  localparam logic [3:0] PE_BACKED   = 4'h3;
  localparam logic [3:0] SEL_IDLE    = 4'hF;
  localparam logic [LOAD_CNT_W-1:0] LOADER_LOW_CLOCKS = 6'h30;
  localparam logic [VEC_AW-1:0] VEC_LAST = 6'h2F;
  localparam int SCR_ROT = 5;
  typedef enum logic [2:0] {ACC_IDLE = 3'b001, ACC_LATCH = 3'b010, ACC_STROBE = 3'b100} acc_state_t;
  typedef enum logic [1:0] {V_IDLE = 2'b01, V_ERASE = 2'b10} vault_state_t;
endpackage : sram_sel_pkg

// ==== shared/vault_if.sv ====
// carrier between the select logic and the key and vector store
`timescale 1ns/1ps
interface vault_if;
  logic [63:0] key;
  logic [63:0] trng;
  logic        key_load;
  logic        key_valid;
  logic        erase_req;
  logic        erasing;
  logic [5:0]  vec_addr;
  logic [7:0]  vec_wdata;
  logic        vec_we;
  logic [7:0]  vec_rdata;
  modport vault (input trng, key_load, erase_req, vec_addr, vec_wdata, vec_we,
                 output key, key_valid, erasing, vec_rdata);
  modport user (output trng, key_load, erase_req, vec_addr, vec_wdata, vec_we,
                input key, key_valid, erasing, vec_rdata);
endinterface : vault_if

// ==== logic/key_vault.sv ====
// key word and vector byte store with erase sweep
`timescale 1ns/1ps
module key_vault (
  input wire logic clock_i,
  input wire logic nrst_i,
  vault_if.vault   vif
);
  sram_sel_pkg::vault_state_t state_reg, state_next;
  logic [63:0] key_reg, key_next;
  logic        valid_reg, valid_next;
  logic [5:0]  sweep_reg, sweep_next;
  logic [7:0]  mem [0:47];
  logic [7:0]  rd_reg;
  // ***********************************************
  // erase sequence and key load
  // ***********************************************
  always_comb begin
    state_next = state_reg;
    key_next   = key_reg;
    valid_next = valid_reg;
    sweep_next = sweep_reg;
    unique case (state_reg)
      sram_sel_pkg::V_IDLE: begin
        if (vif.key_load) begin
          key_next   = vif.trng;
          valid_next = 1'b1;
        end
      end
      sram_sel_pkg::V_ERASE: begin
        sweep_next = sweep_reg + 6'h01;
        if (sweep_reg == sram_sel_pkg::VEC_LAST) state_next = sram_sel_pkg::V_IDLE;
      end
    endcase
    if (vif.erase_req) begin
      key_next   = '0;
      valid_next = 1'b0;
      sweep_next = '0;
      state_next = sram_sel_pkg::V_ERASE;
    end
  end
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= sram_sel_pkg::V_IDLE;
      key_reg   <= '0;
      valid_reg <= 1'b0;
      sweep_reg <= '0;
    end else begin
      state_reg <= state_next;
      key_reg   <= key_next;
      valid_reg <= valid_next;
      sweep_reg <= sweep_next;
    end
  end
  // vector bytes: zero sweep wins over software writes
  always_ff @(posedge clock_i) begin
    if (state_reg == sram_sel_pkg::V_ERASE) begin
      mem[sweep_reg] <= 8'h00;
    end else if (vif.vec_we && vif.vec_addr <= sram_sel_pkg::VEC_LAST) begin
      mem[vif.vec_addr] <= vif.vec_wdata;
    end
  end
  // registered read port
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_reg <= 8'h00;
    end else if (vif.vec_addr <= sram_sel_pkg::VEC_LAST) begin
      rd_reg <= mem[vif.vec_addr];
    end else begin
      rd_reg <= 8'h00;
    end
  end
  assign vif.key       = key_reg;
  assign vif.key_valid = valid_reg;
  assign vif.erasing   = (state_reg == sram_sel_pkg::V_ERASE);
  assign vif.vec_rdata = rd_reg;
endmodule : key_vault

// ==== logic/addr_scrambler.sv ====
// key dependent one to one logical to physical address map
`timescale 1ns/1ps
module addr_scrambler (
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  input  wire logic [63:0] key_i,
  input  wire logic        load_i,
  input  wire logic [15:0] logical_i,
  output logic      [15:0] phys_o
);
  logic [15:0] phys_reg, phys_next;
  // xor, fixed rotate, xor: every step is invertible
  function automatic logic [15:0] scramble(input logic [15:0] a, input logic [63:0] k);
    logic [15:0] x;
    x = a ^ k[15:0];
    x = {x[15-sram_sel_pkg::SCR_ROT:0], x[15:16-sram_sel_pkg::SCR_ROT]};
    return x ^ k[31:16] ^ k[47:32] ^ k[63:48];
  endfunction : scramble
  always_comb begin
    phys_next = load_i ? scramble(logical_i, key_i) : phys_reg;
  end
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phys_reg <= '0;
    end else begin
      phys_reg <= phys_next;
    end
  end
  assign phys_o = phys_reg;
endmodule : addr_scrambler

// ==== logic/secure_sram_bus_select.sv ====
// chip and peripheral select, reset, loader and tamper logic of the byte-wide bus
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module secure_sram_bus_select (
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  input  wire logic        reset_i,
  input  wire logic        loader_entry_pin_i,
  input  wire logic        low_supply_reset_pin_i,
  input  wire logic        supply_below_min_i,
  input  wire logic        lithium_input_i,
  input  wire logic        tamper_erase_input_i,
  input  wire logic        memory_size_pin_i,
  input  wire logic [63:0] trng_bits_i,
  input  wire logic        access_req_i,
  input  wire logic        access_data_i,
  input  wire logic        access_write_i,
  input  wire logic [15:0] logical_addr_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_write_i,
  input  wire logic        reg_read_i,
  output logic      [7:0]  reg_rdata_o,
  output logic      [14:0] phys_addr_o,
  output logic             addr_latch_enable_o,
  output logic             write_enable_n_o,
  output logic             sram_select_primary_o,
  output logic             sram_select_second_o,
  output logic             sram_select_third_o,
  output logic             sram_select_fourth_o,
  output logic             sram_select_primary_unbacked_o,
  output logic             periph_select_one_o,
  output logic             periph_select_two_o,
  output logic             periph_select_three_o,
  output logic             periph_select_four_o,
  output logic             low_supply_reset_pin_o,
  output logic             low_supply_reset_pin_oe_o,
  output logic             battery_backup_flag_n_o,
  output logic             sram_supply_enable_o,
  output logic             in_reset_o,
  output logic             loader_active_o
);
  // ***********************************************
  // declarations
  // ***********************************************
  vault_if vif ();
  sram_sel_pkg::acc_state_t acc_reg, acc_next;
  logic        rst_state_reg, rst_state_next;
  logic        low_supply_reset_pin_oe_reg, low_supply_reset_pin_oe_next;
  logic        flag_n_reg, flag_n_next;
  logic        loader_entry_pin_prev_reg, loader_entry_pin_prev_next;
  logic        armed_reg, armed_next;
  logic        first_reg, first_next;
  logic        loader_reg, loader_next;
  logic [5:0]  low_cnt_reg, low_cnt_next;
  logic        pes_reg, pes_next;
  logic        lock_reg, lock_next;
  logic        supply_reg, supply_next;
  logic [5:0]  vec_addr_reg, vec_addr_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic        space_reg, space_next;
  logic        write_reg, write_next;
  logic [15:0] laddr_reg, laddr_next;
  logic        ale_reg, ale_next;
  logic        we_n_reg, we_n_next;
  logic [3:0]  ce_n_reg, ce_n_next;
  logic        sram_select_primary_unbacked_reg, sram_select_primary_unbacked_next;
  logic [3:0]  pe_n_reg, pe_n_next;
  logic [14:0] phys_out_reg, phys_out_next;
  logic [15:0] scr_phys;
  logic [3:0]  pe_hit;
  logic [3:0]  block_hot;
  logic [1:0]  block;
  logic        periph;
  logic        take_req;
  logic        wr_cfg;
  logic        lock_clear_ev;
  logic        keygen;
  logic [7:0]  status;
  // ***********************************************
  // submodules
  // ***********************************************
  key_vault u_vault (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .vif     (vif.vault)
  );
  addr_scrambler u_scr (
    .clock_i   (clock_i),
    .nrst_i    (nrst_i),
    .key_i     (vif.key),
    .load_i    (take_req),
    .logical_i (logical_addr_i),
    .phys_o    (scr_phys)
  );
  // ***********************************************
  // reset, supply status and low-supply pin
  // ***********************************************
  // reset state from the pin, the shared low-supply pin and supply level
  always_comb begin
    rst_state_next = reset_i | ~low_supply_reset_pin_i | supply_below_min_i;
    low_supply_reset_pin_oe_next   = supply_below_min_i;
    flag_n_next    = ~lithium_input_i;
  end
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_state_reg <= 1'b1;
      low_supply_reset_pin_oe_reg   <= 1'b0;
      flag_n_reg    <= 1'b1;
    end else begin
      rst_state_reg <= rst_state_next;
      low_supply_reset_pin_oe_reg   <= low_supply_reset_pin_oe_next;
      flag_n_reg    <= flag_n_next;
    end
  end
  // ***********************************************
  // loader entry
  // ***********************************************
  // arm on a falling edge or a grounded pin at power-up, enter after the low time
  always_comb begin
    loader_entry_pin_prev_next = loader_entry_pin_i;
    first_next     = 1'b0;
    armed_next     = armed_reg;
    loader_next    = loader_reg;
    low_cnt_next   = low_cnt_reg;
    if (loader_entry_pin_i) begin
      armed_next   = 1'b0;
      loader_next  = 1'b0;
      low_cnt_next = '0;
    end else begin
      if (first_reg || loader_entry_pin_prev_reg) armed_next = 1'b1;
      if (low_cnt_reg != sram_sel_pkg::LOADER_LOW_CLOCKS) low_cnt_next = low_cnt_reg + 6'h01;
      if (armed_reg && low_cnt_next == sram_sel_pkg::LOADER_LOW_CLOCKS) begin
        loader_next = 1'b1;
        armed_next  = 1'b0;
      end
    end
  end
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      loader_entry_pin_prev_reg <= 1'b1;
      first_reg     <= 1'b1;
      armed_reg     <= 1'b0;
      loader_reg    <= 1'b0;
      low_cnt_reg   <= '0;
    end else begin
      loader_entry_pin_prev_reg <= loader_entry_pin_prev_next;
      first_reg     <= first_next;
      armed_reg     <= armed_next;
      loader_reg    <= loader_next;
      low_cnt_reg   <= low_cnt_next;
    end
  end
  // ***********************************************
  // register port
  // ***********************************************
  assign wr_cfg        = reg_write_i && reg_addr_i == sram_sel_pkg::REG_CONFIG;
  assign lock_clear_ev = wr_cfg && lock_reg && !reg_wdata_i[sram_sel_pkg::CFG_LOCK_BIT];
  assign keygen        = reg_write_i && reg_addr_i == sram_sel_pkg::REG_CONTROL
                         && reg_wdata_i[sram_sel_pkg::CTL_KEYGEN_BIT] && !lock_reg;
  // status word
  always_comb begin
    status                           = 8'h00;
    status[sram_sel_pkg::ST_LOADER]  = loader_reg;
    status[sram_sel_pkg::ST_ERASE]   = vif.erasing;
    status[sram_sel_pkg::ST_BACKUP]  = ~flag_n_reg;
    status[sram_sel_pkg::ST_RESET]   = rst_state_reg;
    status[sram_sel_pkg::ST_KEYOK]   = vif.key_valid;
    status[sram_sel_pkg::ST_SUPPLY]  = supply_reg;
  end
  // config, lock, supply switch and read data
  always_comb begin
    pes_next      = pes_reg;
    lock_next     = lock_reg;
    supply_next   = supply_reg;
    vec_addr_next = vec_addr_reg;
    rdata_next    = rdata_reg;
    if (wr_cfg) begin
      pes_next = reg_wdata_i[sram_sel_pkg::CFG_PES_BIT];
      lock_next = reg_wdata_i[sram_sel_pkg::CFG_LOCK_BIT] && vif.key_valid;
    end
    if (reg_write_i && reg_addr_i == sram_sel_pkg::REG_VEC_ADDR) begin
      vec_addr_next = reg_wdata_i[5:0];
    end
    if (keygen) supply_next = 1'b1;
    if (rst_state_reg) pes_next = 1'b0;
    if (tamper_erase_input_i) begin
      lock_next   = 1'b0;
      supply_next = 1'b0;
    end
    if (reg_read_i) begin
      unique case (reg_addr_i)
        sram_sel_pkg::REG_CONFIG:   rdata_next = {6'h00, lock_reg, pes_reg};
        sram_sel_pkg::REG_STATUS:   rdata_next = status;
        sram_sel_pkg::REG_VEC_ADDR: rdata_next = {2'h0, vec_addr_reg};
        sram_sel_pkg::REG_VEC_DATA: rdata_next = vif.vec_rdata;
        default:                    rdata_next = 8'h00;
      endcase
    end
  end
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pes_reg      <= 1'b0;
      lock_reg     <= 1'b0;
      supply_reg   <= 1'b1;
      vec_addr_reg <= '0;
      rdata_reg    <= 8'h00;
    end else begin
      pes_reg      <= pes_next;
      lock_reg     <= lock_next;
      supply_reg   <= supply_next;
      vec_addr_reg <= vec_addr_next;
      rdata_reg    <= rdata_next;
    end
  end
  // vault requests
  assign vif.trng      = trng_bits_i;
  assign vif.key_load  = keygen;
  assign vif.erase_req = tamper_erase_input_i | lock_clear_ev;
  assign vif.vec_addr  = vec_addr_reg;
  assign vif.vec_wdata = reg_wdata_i;
  assign vif.vec_we    = reg_write_i && reg_addr_i == sram_sel_pkg::REG_VEC_DATA && !lock_reg;
  // ***********************************************
  // address decode
  // ***********************************************
  // peripheral windows on the logical data address
  for (genvar g = 0; g < 4; g++) begin : g_pe
    assign pe_hit[g] = laddr_reg >= sram_sel_pkg::PE_BASE[g]
                       && laddr_reg <= sram_sel_pkg::PE_TOP[g];
  end
  assign periph    = space_reg && pes_reg;
  assign block     = {space_reg, scr_phys[15]};
  assign block_hot = 4'h1 << block;
  assign take_req  = access_req_i && acc_reg == sram_sel_pkg::ACC_IDLE && !rst_state_reg;
  // ***********************************************
  // bus access sequence
  // ***********************************************
  // idle, latch cycle with the strobe, then one select cycle
  always_comb begin
    acc_next      = acc_reg;
    space_next    = space_reg;
    write_next    = write_reg;
    laddr_next    = laddr_reg;
    ale_next      = 1'b0;
    we_n_next     = 1'b1;
    ce_n_next     = sram_sel_pkg::SEL_IDLE;
    sram_select_primary_unbacked_next     = 1'b1;
    pe_n_next     = sram_sel_pkg::SEL_IDLE;
    phys_out_next = phys_out_reg;
    unique case (acc_reg)
      sram_sel_pkg::ACC_IDLE: begin
        if (take_req) begin
          space_next = access_data_i;
          write_next = access_write_i;
          laddr_next = logical_addr_i;
          ale_next   = 1'b1;
          acc_next   = sram_sel_pkg::ACC_LATCH;
        end
      end
      sram_sel_pkg::ACC_LATCH: begin
        acc_next      = sram_sel_pkg::ACC_STROBE;
        phys_out_next = scr_phys[14:0];
        we_n_next     = ~(write_reg && (space_reg || loader_reg));
        if (periph) begin
          pe_n_next = ~pe_hit;
        end else if (memory_size_pin_i) begin
          ce_n_next = ~block_hot;
          sram_select_primary_unbacked_next = ~block_hot[0];
        end else begin
          ce_n_next = {1'b1, block[0], block[1], 1'b0};
          sram_select_primary_unbacked_next = 1'b0;
        end
      end
      sram_sel_pkg::ACC_STROBE: begin
        acc_next = sram_sel_pkg::ACC_IDLE;
      end
    endcase
    if (rst_state_reg) begin
      acc_next  = sram_sel_pkg::ACC_IDLE;
      we_n_next = 1'b1;
      ce_n_next = sram_sel_pkg::SEL_IDLE;
      sram_select_primary_unbacked_next = 1'b1;
      pe_n_next = sram_sel_pkg::SEL_IDLE;
    end
    if (lithium_input_i) begin
      ce_n_next = sram_sel_pkg::SEL_IDLE;
      pe_n_next = pe_n_next | sram_sel_pkg::PE_BACKED;
    end
  end
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc_reg      <= sram_sel_pkg::ACC_IDLE;
      space_reg    <= 1'b0;
      write_reg    <= 1'b0;
      laddr_reg    <= '0;
      ale_reg      <= 1'b0;
      we_n_reg     <= 1'b1;
      ce_n_reg     <= sram_sel_pkg::SEL_IDLE;
      sram_select_primary_unbacked_reg     <= 1'b1;
      pe_n_reg     <= sram_sel_pkg::SEL_IDLE;
      phys_out_reg <= '0;
    end else begin
      acc_reg      <= acc_next;
      space_reg    <= space_next;
      write_reg    <= write_next;
      laddr_reg    <= laddr_next;
      ale_reg      <= ale_next;
      we_n_reg     <= we_n_next;
      ce_n_reg     <= ce_n_next;
      sram_select_primary_unbacked_reg     <= sram_select_primary_unbacked_next;
      pe_n_reg     <= pe_n_next;
      phys_out_reg <= phys_out_next;
    end
  end
  // ***********************************************
  // outputs
  // ***********************************************
  assign reg_rdata_o                    = rdata_reg;
  assign phys_addr_o                    = phys_out_reg;
  assign addr_latch_enable_o            = ale_reg;
  assign write_enable_n_o               = we_n_reg;
  assign sram_select_primary_o          = ce_n_reg[0];
  assign sram_select_second_o           = ce_n_reg[1];
  assign sram_select_third_o            = ce_n_reg[2];
  assign sram_select_fourth_o           = ce_n_reg[3];
  assign sram_select_primary_unbacked_o = sram_select_primary_unbacked_reg;
  assign periph_select_one_o            = pe_n_reg[0];
  assign periph_select_two_o            = pe_n_reg[1];
  assign periph_select_three_o          = pe_n_reg[2];
  assign periph_select_four_o           = pe_n_reg[3];
  assign low_supply_reset_pin_o         = 1'b0; // open drain: only ever pulls low
  assign low_supply_reset_pin_oe_o      = low_supply_reset_pin_oe_reg;
  assign battery_backup_flag_n_o        = flag_n_reg;
  assign sram_supply_enable_o           = supply_reg;
  assign in_reset_o                     = rst_state_reg;
  assign loader_active_o                = loader_reg;
endmodule : secure_sram_bus_select

// ==== sim/byte_bus_model.sv ====
// far-side SRAM and peripheral bank with the open-drain reset wire
`timescale 1ns/1ps
module byte_bus_model (
  input  wire logic       clock_i,
  input  wire logic       ale_i,
  input  wire logic [8:0] strobe_n_i,
  input  wire logic       pin_oe_i,
  input  wire logic       ext_pull_i,
  output logic            pin_level_o,
  output logic [8:0]      seen_n_o
);
  // wired level: device driver, outside pull, internal pull-up
  assign pin_level_o = !(pin_oe_i || ext_pull_i);
  // last select pattern seen, cleared at each address strobe
  always @(posedge clock_i) begin
    if (ale_i) seen_n_o <= '1;
    else if (!(&strobe_n_i[7:0])) seen_n_o <= strobe_n_i;
  end
endmodule : byte_bus_model

// ==== sim/secure_sram_bus_select_chk.sv ====
// assertions on the pins of the byte-wide bus select block
`timescale 1ns/1ps
module secure_sram_bus_select_chk (
  input wire logic clock_i, nrst_i, reset_i, low_supply_reset_pin_i, supply_below_min_i,
  input wire logic lithium_input_i, tamper_erase_input_i, memory_size_pin_i, access_req_i,
  input wire logic access_data_i, addr_latch_enable_o, write_enable_n_o, loader_active_o,
  input wire logic sram_select_primary_o, sram_select_second_o, sram_select_third_o,
  input wire logic sram_select_fourth_o, sram_select_primary_unbacked_o, periph_select_one_o,
  input wire logic periph_select_two_o, periph_select_three_o, periph_select_four_o,
  input wire logic low_supply_reset_pin_oe_o, battery_backup_flag_n_o, sram_supply_enable_o,
  input wire logic in_reset_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // selects gathered, peripheral four down to primary
  logic [7:0] sel_n;
  assign sel_n = {periph_select_four_o, periph_select_three_o, periph_select_two_o,
    periph_select_one_o, sram_select_fourth_o, sram_select_third_o, sram_select_second_o,
    sram_select_primary_o};
  chk_ale_single: assert property (addr_latch_enable_o |=> !addr_latch_enable_o)
    else $error("latch strobe longer than one cycle");
  chk_ale_cause: assert property (addr_latch_enable_o |-> $past(access_req_i))
    else $error("latch strobe without request");
  chk_one_select: assert property (memory_size_pin_i [*2] |-> $countones(~sel_n) <= 1)
    else $error("more than one select low");
  chk_fourth_idle: assert property (!memory_size_pin_i [*2] |-> sram_select_fourth_o)
    else $error("fourth select low with one large part");
  chk_backup_hold: assert property (lithium_input_i [*2] |-> &sel_n[5:0])
    else $error("backed select low in backup");
  chk_unbacked_copy: assert property (!lithium_input_i [*2] |->
    sram_select_primary_unbacked_o == sram_select_primary_o) else $error("unbacked copy differs");
  chk_flag_backup: assert property (lithium_input_i |=> !battery_backup_flag_n_o)
    else $error("backup flag not low");
  chk_reset_level: assert property (reset_i || !low_supply_reset_pin_i |=> in_reset_o)
    else $error("reset state not entered");
  chk_supply_reset: assert property (supply_below_min_i |=> low_supply_reset_pin_oe_o)
    else $error("reset pin not pulled low");
  chk_tamper_power: assert property (tamper_erase_input_i |=> !sram_supply_enable_o)
    else $error("supply kept on under tamper");
  chk_write_guard: assert property (!write_enable_n_o |->
    $past(access_data_i, 2) || $past(loader_active_o)) else $error("program space written");
  cov_write: cover property (!write_enable_n_o);
  cov_backup_pe: cover property (lithium_input_i && !periph_select_three_o);
  cov_loader: cover property ($rose(loader_active_o));
endmodule : secure_sram_bus_select_chk
bind secure_sram_bus_select secure_sram_bus_select_chk i_chk (.*);

// ==== sim/test_secure_sram_bus_select.sv ====
// self-checking bench of the byte-wide bus select block
`timescale 1ns/1ps
module test_secure_sram_bus_select;
  logic clock_i, nrst_i, reset_i, loader_entry_pin_i, low_supply_reset_pin_i, ext_pull;
  logic supply_below_min_i, lithium_input_i, tamper_erase_input_i, memory_size_pin_i;
  logic access_req_i, access_data_i, access_write_i, reg_write_i, reg_read_i;
  logic [63:0] trng_bits_i;
  logic [15:0] logical_addr_i;
  logic [3:0]  reg_addr_i;
  logic [7:0]  reg_wdata_i, reg_rdata_o;
  logic [14:0] phys_addr_o;
  logic [8:0]  seen_n;
  logic addr_latch_enable_o, write_enable_n_o, sram_select_primary_o, sram_select_second_o;
  logic sram_select_third_o, sram_select_fourth_o, sram_select_primary_unbacked_o;
  logic periph_select_one_o, periph_select_two_o, periph_select_three_o, periph_select_four_o;
  logic low_supply_reset_pin_o, low_supply_reset_pin_oe_o, battery_backup_flag_n_o;
  logic sram_supply_enable_o, in_reset_o, loader_active_o;
  int   n_fail, comparisons;
  secure_sram_bus_select i_dut (.*);
  byte_bus_model i_far (.clock_i, .ale_i(addr_latch_enable_o), .pin_oe_i(low_supply_reset_pin_oe_o),
    .strobe_n_i({write_enable_n_o, periph_select_four_o, periph_select_three_o,
    periph_select_two_o, periph_select_one_o, sram_select_fourth_o, sram_select_third_o,
    sram_select_second_o, sram_select_primary_o}), .ext_pull_i(ext_pull),
    .pin_level_o(low_supply_reset_pin_i), .seen_n_o(seen_n));
  // clock of 25 ns period
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask : cyc
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one bus access, pattern {we_n, pe4..pe1, ce4..ce1} seen by the far side
  task automatic acc(input logic d, w, input logic [15:0] a, input logic [8:0] msk, exp);
    cyc(1);
    {access_req_i, access_data_i, access_write_i, logical_addr_i} <= {1'b1, d, w, a};
    cyc(1);
    access_req_i <= 1'b0;
    cyc(3);
    check(seen_n & msk, exp);
  endtask : acc
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    cyc(1);
    {reg_write_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
    cyc(1);
    reg_write_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] msk, exp);
    cyc(1);
    {reg_read_i, reg_addr_i} <= {1'b1, a};
    cyc(1);
    reg_read_i <= 1'b0;
    #1 check({1'b0, reg_rdata_o & msk}, {1'b0, exp});
  endtask : rd
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test
  // watchdog against a hung sequence
  initial begin
    #40us;
    n_fail++;
    $display("ERROR at %0t: watchdog expired", $time);
    end_of_test();
  end
  // main sequence
  initial begin
    {nrst_i, reset_i, supply_below_min_i, lithium_input_i, tamper_erase_input_i} = '0;
    {access_req_i, access_data_i, access_write_i, reg_write_i, reg_read_i, ext_pull} = '0;
    {loader_entry_pin_i, memory_size_pin_i, n_fail, comparisons} = {2'b11, 64'h0};
    {trng_bits_i, logical_addr_i, reg_addr_i, reg_wdata_i} = {64'hA5C30F1E7B29D486, 28'h0};
    cyc(6);
    nrst_i <= 1'b1;
    rd(sram_sel_pkg::REG_STATUS, 8'h2F, 8'h20);
    rd(4'hF, 8'hFF, 8'h00);
    wr(sram_sel_pkg::REG_CONFIG, 8'h01);
    for (int q = 0; q < 4; q++) begin
      acc(1, 1, sram_sel_pkg::PE_BASE[q], 9'h1FF, {1'b0, ~(4'h1 << q), 4'hF});
      acc(1, 0, sram_sel_pkg::PE_TOP[q], 9'h1FF, {1'b1, ~(4'h1 << q), 4'hF});
    end
    wr(sram_sel_pkg::REG_CONFIG, 8'h00);
    acc(0, 1, 16'h1234, 9'h1FC, 9'h1FC);
    check({8'h0, phys_addr_o == 15'h4682}, 9'h1);
    acc(1, 1, 16'h1234, 9'h1F3, 9'h0F3);
    memory_size_pin_i <= 1'b0;
    acc(1, 1, 16'h4321, 9'h1FB, 9'h0FA);
    acc(0, 0, 16'h4321, 9'h1FB, 9'h1F8);
    {memory_size_pin_i, lithium_input_i} <= 2'b11;
    wr(sram_sel_pkg::REG_CONFIG, 8'h01);
    acc(1, 1, 16'h0100, 9'h0FF, 9'h0FF);
    acc(1, 0, 16'h8100, 9'h1FF, 9'h1BF);
    check({8'h0, battery_backup_flag_n_o}, 9'h0);
    {lithium_input_i, reset_i} <= 2'b01;
    cyc(2);
    #1 check({8'h0, in_reset_o}, 9'h1);
    cyc(1);
    {reset_i, supply_below_min_i} <= 2'b01;
    cyc(2);
    #1 check({7'h0, low_supply_reset_pin_oe_o, in_reset_o}, 9'h3);
    cyc(1);
    {supply_below_min_i, ext_pull} <= 2'b01;
    cyc(3);
    #1 check({8'h0, in_reset_o}, 9'h1);
    cyc(1);
    ext_pull <= 1'b0;
    cyc(3);
    loader_entry_pin_i <= 1'b0;
    cyc(47);
    #1 check({8'h0, loader_active_o}, 9'h0);
    cyc(1);
    #1 check({8'h0, loader_active_o}, 9'h1);
    acc(0, 1, 16'h0042, 9'h100, 9'h000);
    loader_entry_pin_i <= 1'b1;
    wr(sram_sel_pkg::REG_CONTROL, 8'h01);
    rd(sram_sel_pkg::REG_STATUS, 8'h31, 8'h30);
    wr(sram_sel_pkg::REG_VEC_ADDR, 8'h05);
    wr(sram_sel_pkg::REG_VEC_DATA, 8'h5A);
    rd(sram_sel_pkg::REG_VEC_DATA, 8'hFF, 8'h5A);
    cyc(1);
    {reset_i, tamper_erase_input_i} <= 2'b11;
    cyc(2);
    #1 check({8'h0, sram_supply_enable_o}, 9'h0);
    cyc(1);
    {reset_i, tamper_erase_input_i} <= 2'b00;
    rd(sram_sel_pkg::REG_STATUS, 8'h32, 8'h02);
    cyc(50);
    rd(sram_sel_pkg::REG_VEC_DATA, 8'hFF, 8'h00);
    cyc(1);
    {nrst_i, loader_entry_pin_i} <= 2'b00;
    cyc(2);
    check({7'h0, in_reset_o, sram_supply_enable_o}, 9'h3);
    nrst_i <= 1'b1;
    cyc(47);
    #1 check({8'h0, loader_active_o}, 9'h0);
    cyc(1);
    #1 check({8'h0, loader_active_o}, 9'h1);
    end_of_test();
  end
endmodule : test_secure_sram_bus_select
